// ==== verilog/tve_map.vh ====
// constants for the thermocouple value encoder
`ifndef TVE_MAP_VH
`define TVE_MAP_VH

// ----------------------------------------
// word codes
// ----------------------------------------
`define TVE_W_MAX      16'h7fff
`define TVE_W_MIN      16'h8000
`define TVE_W_ZERO     16'h0000

// ----------------------------------------
// type T limits, tenths of a degree
// ----------------------------------------
`define TVE_T_NOM_HI   24'sd4000
`define TVE_T_NOM_LO   -24'sd2700
`define TVE_T_OVR_HI   24'sd5400
`define TVE_T_UND_LO   -24'sd2700

// ----------------------------------------
// millivolt range, microvolts and codes
// ----------------------------------------
`define TVE_MV_FS_UV   24'sd80000
`define TVE_MV_FS_CODE 24'sd27648
`define TVE_MV_OVR_HI  24'sd32511
`define TVE_MV_UND_LO  -24'sd32512

// ----------------------------------------
// modes and range classes
// ----------------------------------------
`define TVE_MODE_TC_T  1'b0
`define TVE_MODE_MV    1'b1
`define TVE_CLS_NOM    3'h0
`define TVE_CLS_OVR    3'h1
`define TVE_CLS_UND    3'h2
`define TVE_CLS_OFL    3'h3
`define TVE_CLS_UFL    3'h4

// ----------------------------------------
// legacy word overflow bit and pin filter depth
// ----------------------------------------
`define TVE_LEG_OFL_BIT 0
`define TVE_SYNC_LEN   3

`endif

// ==== verilog/tve_sync.v ====
// three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/100ps
module tve_sync (
	input wire CLK_SYS_I,
	input wire RST_I,
	input wire pin_i,
	output reg level_o
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	// ----------------------------------------
	// stages; level moves only when stages two and three agree
	// ----------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_o <= 1'b0;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) level_o <= s3_r;
		end
	end
endmodule // tve_sync

// ==== verilog/tve_classify.v ====
// range classification and scaling of one raw measurement
`timescale 1ns/100ps
`include "tve_map.vh"
module tve_classify (
	input wire mode_i,
	input wire signed [23:0] raw_i,
	output reg [2:0] cls_o,
	output reg signed [15:0] val_o
);
	reg signed [47:0] prod;
	reg signed [23:0] scaled;

	// millivolt scaling: uV * 27648 / 80000, truncated toward zero
	function signed [23:0] mv_scale;
		input signed [23:0] uv;
		reg signed [47:0] p;
		reg signed [47:0] q;
		begin
			p = uv * `TVE_MV_FS_CODE;
			q = p / `TVE_MV_FS_UV;
			mv_scale = q[23:0];
		end
	endfunction

	// ----------------------------------------
	// classify; the top band edges decide overflow
	// ----------------------------------------
	always @* begin
		prod = 48'sd0;
		scaled = 24'sd0;
		cls_o = `TVE_CLS_NOM;
		val_o = 16'sd0;
		if (mode_i == `TVE_MODE_MV) begin
			scaled = mv_scale(raw_i); // RL2
			if (scaled > `TVE_MV_OVR_HI) cls_o = `TVE_CLS_OFL; // RL3
			else if (scaled < `TVE_MV_UND_LO) cls_o = `TVE_CLS_UFL; // RL3
			else if (scaled > `TVE_MV_FS_CODE) cls_o = `TVE_CLS_OVR;
			else if (scaled < -`TVE_MV_FS_CODE) cls_o = `TVE_CLS_UND;
		end else begin
			scaled = raw_i; // RL1
			if (scaled > `TVE_T_OVR_HI) cls_o = `TVE_CLS_OFL; // RL1
			else if (scaled < `TVE_T_UND_LO) cls_o = `TVE_CLS_UFL;
			else if (scaled > `TVE_T_NOM_HI) cls_o = `TVE_CLS_OVR;
		end
		val_o = scaled[15:0];
	end
endmodule // tve_classify

// ==== verilog/tve_encoder.v ====
// two-channel input word encoder for thermocouple / millivolt readout
`timescale 1ns/100ps
`include "tve_map.vh"

// How it works
// RL1 - type T tenths, limits 4000/5400, saturate beyond
// RL2 - millivolt full scale maps to 27648
// RL3 - millivolt bands reach 32511 and -32512
// RL4 - in-range values pass unchanged, both formats
// RL5 - primary: overflow 7fff, underflow 8000
// RL6 - legacy overflow: top plus one, flag
// RL7 - legacy underflow: bottom minus one, flag
// RL8 - unassigned or bad parameters give 7fff
// RL9 - 7fff until first conversion after setup
// RL10 - missing load supply gives 7fff
// RL11 - live values in run and stop
// RL12 - open wire with diagnostics gives 32767
// RL13 - primary word is two's complement
module tve_encoder #(
	parameter NCH = 2
) (
	input wire CLK_SYS_I,
	input wire RST_I,
	input wire [3:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [31:0] RDATA_O,
	output reg IRQ_O,
	input wire [NCH-1:0] CONV_VALID_I,
	input wire [24*NCH-1:0] CONV_DATA_I,
	input wire [NCH-1:0] OPEN_WIRE_I,
	input wire LOAD_SUPPLY_I,
	input wire CTRL_RUN_I,
	output reg [16*NCH-1:0] PRI_WORD_O,
	output reg [16*NCH-1:0] LEG_WORD_O,
	output reg [NCH-1:0] OPEN_DIAG_O
);
	// ----------------------------------------
	// register offsets (word index on the plain port)
	// ----------------------------------------
	localparam [3:0] A_CFG = 4'h0;
	localparam [3:0] A_STAT = 4'h1;
	localparam [3:0] A_MASK = 4'h2;
	localparam [3:0] A_CH0 = 4'h3;
	localparam [3:0] A_CH1 = 4'h4;

	// cfg: bit0 params assigned, bit1 params bad, bits3:2 ch mode,
	// bit4 wire-break check, bit5 group diagnostics
	localparam CFG_OK = 0;
	localparam CFG_BAD = 1;
	localparam CFG_MODE = 2;
	localparam CFG_WB = 4;
	localparam CFG_GD = 5;

	// status events: [NCH-1:0] overflow/underflow, [2NCH-1:NCH] open wire,
	// bit 2NCH load supply lost
	localparam NEV = 2 * NCH + 1;

	// saturation codes one count past each band edge, full width first
	localparam signed [23:0] MV_OFL_V = `TVE_MV_OVR_HI + 24'sd1;
	localparam signed [23:0] MV_UFL_V = `TVE_MV_UND_LO - 24'sd1;
	localparam signed [23:0] TC_OFL_V = `TVE_T_OVR_HI + 24'sd1;
	localparam signed [23:0] TC_UFL_V = `TVE_T_UND_LO - 24'sd1;

	reg [5:0] cfg_r;
	reg [NEV-1:0] stat_r;
	reg [NEV-1:0] stat_nxt;
	reg [NEV-1:0] mask_r;
	reg [NCH-1:0] fresh_r;
	reg [NCH-1:0] fresh_nxt;
	reg [NEV-1:0] ev;
	reg [16*NCH-1:0] pri_nxt;
	reg [16*NCH-1:0] leg_nxt;
	reg [NCH-1:0] diag_nxt;
	reg [31:0] rdata_nxt;
	reg load_lost_q_r;
	wire load_ok;
	wire run_lvl;
	wire [NCH-1:0] open_lvl;
	wire [3*NCH-1:0] cls_w;
	wire [16*NCH-1:0] val_w;
	wire params_good;
	integer k;

	// legacy word: value shifted left, low bit is the overflow flag
	function [15:0] leg_pack;
		input [15:0] v;
		input ofl;
		begin
			leg_pack = {v[14:0], ofl};
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	tve_sync u_load (
		.CLK_SYS_I(CLK_SYS_I),
		.RST_I(RST_I),
		.pin_i(LOAD_SUPPLY_I),
		.level_o(load_ok)
	);

	// run/stop only reported; values stay live either way
	tve_sync u_run (
		.CLK_SYS_I(CLK_SYS_I),
		.RST_I(RST_I),
		.pin_i(CTRL_RUN_I),
		.level_o(run_lvl)
	);

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			tve_sync u_open (
				.CLK_SYS_I(CLK_SYS_I),
				.RST_I(RST_I),
				.pin_i(OPEN_WIRE_I[g]),
				.level_o(open_lvl[g])
			);
			tve_classify u_cls (
				.mode_i(cfg_r[CFG_MODE + g]),
				.raw_i(CONV_DATA_I[24*g +: 24]),
				.cls_o(cls_w[3*g +: 3]),
				.val_o(val_w[16*g +: 16])
			);
		end
	endgenerate

	assign params_good = cfg_r[CFG_OK] & ~cfg_r[CFG_BAD];

	// ----------------------------------------
	// word formation per channel
	// ----------------------------------------
	always @* begin
		pri_nxt = PRI_WORD_O;
		leg_nxt = LEG_WORD_O;
		diag_nxt = {NCH{1'b0}};
		fresh_nxt = fresh_r;
		ev = {NEV{1'b0}};
		ev[2*NCH] = ~load_ok & ~load_lost_q_r;
		for (k = 0; k < NCH; k = k + 1) begin
			diag_nxt[k] = open_lvl[k] & cfg_r[CFG_WB] & cfg_r[CFG_GD];
			ev[NCH + k] = diag_nxt[k] & ~OPEN_DIAG_O[k];
			if (CONV_VALID_I[k] && params_good) fresh_nxt[k] = 1'b1; // RL9
			if (!params_good || !load_ok) begin
				pri_nxt[16*k +: 16] = `TVE_W_MAX; // RL8 RL10
				leg_nxt[16*k +: 16] = `TVE_W_MAX; // RL8
			end else if (!fresh_nxt[k]) begin
				pri_nxt[16*k +: 16] = `TVE_W_MAX; // RL9
				leg_nxt[16*k +: 16] = `TVE_W_MAX;
			end else if (diag_nxt[k]) begin
				pri_nxt[16*k +: 16] = `TVE_W_MAX; // RL12
				leg_nxt[16*k +: 16] = `TVE_W_MAX;
			end else if (CONV_VALID_I[k]) begin // RL11
				case (cls_w[3*k +: 3])
				`TVE_CLS_OFL: begin
					pri_nxt[16*k +: 16] = `TVE_W_MAX; // RL5
					ev[k] = 1'b1;
					if (cfg_r[CFG_MODE + k])
						leg_nxt[16*k +: 16] = leg_pack(
							MV_OFL_V[15:0], 1'b1); // RL6
					else
						leg_nxt[16*k +: 16] = leg_pack(
							TC_OFL_V[15:0], 1'b1); // RL6
				end
				`TVE_CLS_UFL: begin
					pri_nxt[16*k +: 16] = `TVE_W_MIN; // RL5
					ev[k] = 1'b1;
					if (cfg_r[CFG_MODE + k])
						leg_nxt[16*k +: 16] = leg_pack(
							MV_UFL_V[15:0], 1'b1); // RL7
					else
						leg_nxt[16*k +: 16] = leg_pack(
							TC_UFL_V[15:0], 1'b1); // RL7
				end
				default: begin
					// two's complement passes as is
					pri_nxt[16*k +: 16] = val_w[16*k +: 16]; // RL4 RL13
					leg_nxt[16*k +: 16] = leg_pack(
						val_w[16*k +: 16], 1'b0); // RL4
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// read mux and sticky status
	// ----------------------------------------
	always @* begin
		rdata_nxt = 32'h0;
		case (ADDR_I)
		A_CFG: rdata_nxt = {25'h0, run_lvl, cfg_r};
		A_STAT: rdata_nxt = {{(32-NEV){1'b0}}, stat_r};
		A_MASK: rdata_nxt = {{(32-NEV){1'b0}}, mask_r};
		A_CH0: rdata_nxt = {LEG_WORD_O[15:0], PRI_WORD_O[15:0]};
		A_CH1: rdata_nxt = {LEG_WORD_O[31:16], PRI_WORD_O[31:16]};
		default: rdata_nxt = 32'h0;
		endcase
		// read clears, but an event in the same cycle survives
		stat_nxt = ((RD_I && ADDR_I == A_STAT) ? {NEV{1'b0}} : stat_r) | ev;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			cfg_r <= 6'h0;
			stat_r <= {NEV{1'b0}};
			mask_r <= {NEV{1'b0}};
			fresh_r <= {NCH{1'b0}};
			load_lost_q_r <= 1'b1;
			PRI_WORD_O <= {NCH{`TVE_W_MAX}};
			LEG_WORD_O <= {NCH{`TVE_W_MAX}};
			OPEN_DIAG_O <= {NCH{1'b0}};
			RDATA_O <= 32'h0;
			IRQ_O <= 1'b0;
		end else begin
			load_lost_q_r <= ~load_ok;
			PRI_WORD_O <= pri_nxt;
			LEG_WORD_O <= leg_nxt;
			OPEN_DIAG_O <= diag_nxt; // RL12
			stat_r <= stat_nxt;
			fresh_r <= fresh_nxt;
			RDATA_O <= RD_I ? rdata_nxt : 32'h0;
			IRQ_O <= |(stat_nxt & mask_r);
			if (WR_I && ADDR_I == A_CFG) begin
				cfg_r <= WDATA_I[5:0];
				fresh_r <= {NCH{1'b0}}; // RL9
			end
			if (WR_I && ADDR_I == A_MASK) mask_r <= WDATA_I[NEV-1:0];
		end
	end
endmodule // tve_encoder

// ==== dv/tve_monitor.sv ====
// assertion checker on the encoder ports
`timescale 1ns/100ps
module tve_monitor #(
	parameter NCH = 2
) (
	input wire CLK_SYS_I,
	input wire RST_I,
	input wire [3:0] ADDR_I,
	input wire WR_I,
	input wire RD_I,
	input wire [31:0] RDATA_O,
	input wire [NCH-1:0] CONV_VALID_I,
	input wire LOAD_SUPPLY_I,
	input wire [16*NCH-1:0] PRI_WORD_O,
	input wire [16*NCH-1:0] LEG_WORD_O,
	input wire [NCH-1:0] OPEN_DIAG_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	// read data only after a read of a mapped index
	property p_rd0;
		!RD_I || ADDR_I > 4'h4 |=> RDATA_O == 32'h0;
	endproperty
	a_rd0: assert property (p_rd0) else $error("stray read data");
	// in-range values reach both formats unchanged
	property p_pass0;
		PRI_WORD_O[15:0] != 16'h7fff && PRI_WORD_O[15:0] != 16'h8000
			|-> LEG_WORD_O[15:0] == {PRI_WORD_O[14:0], 1'b0};
	endproperty
	a_pass0: assert property (p_pass0) else $error("ch0 pass");
	property p_pass1;
		PRI_WORD_O[31:16] != 16'h7fff && PRI_WORD_O[31:16] != 16'h8000
			|-> LEG_WORD_O[31:16] == {PRI_WORD_O[30:16], 1'b0};
	endproperty
	a_pass1: assert property (p_pass1) else $error("ch1 pass");
	// top code: substitute, or overrange end plus one with flag
	property p_ofl;
		PRI_WORD_O[15:0] == 16'h7fff
			|-> LEG_WORD_O[15:0] inside {16'h7fff, 16'h2a33, 16'hfe01};
	endproperty
	a_ofl: assert property (p_ofl) else $error("overflow word");
	property p_ufl;
		PRI_WORD_O[15:0] == 16'h8000
			|-> LEG_WORD_O[15:0] inside {16'heae7, 16'h01ff};
	endproperty
	a_ufl: assert property (p_ufl) else $error("underflow word");
	// pin filter needs a few edges, so eight low samples
	property p_load;
		!LOAD_SUPPLY_I [*8] |-> PRI_WORD_O == {NCH{16'h7fff}}
			&& LEG_WORD_O == {NCH{16'h7fff}};
	endproperty
	a_load: assert property (p_load) else $error("load lost");
	property p_diag;
		OPEN_DIAG_O[0] |-> PRI_WORD_O[15:0] == 16'h7fff;
	endproperty
	a_diag: assert property (p_diag) else $error("open wire");
	property p_cfg;
		WR_I && ADDR_I == 4'h0 && CONV_VALID_I == 0 ##1
			CONV_VALID_I == 0 [*2] |=> PRI_WORD_O == {NCH{16'h7fff}};
	endproperty
	a_cfg: assert property (p_cfg) else $error("stale word");
endmodule // tve_monitor

bind tve_encoder tve_monitor #(.NCH(NCH)) mon_u (
	.CLK_SYS_I(CLK_SYS_I),
	.RST_I(RST_I),
	.ADDR_I(ADDR_I),
	.WR_I(WR_I),
	.RD_I(RD_I),
	.RDATA_O(RDATA_O),
	.CONV_VALID_I(CONV_VALID_I),
	.LOAD_SUPPLY_I(LOAD_SUPPLY_I),
	.PRI_WORD_O(PRI_WORD_O),
	.LEG_WORD_O(LEG_WORD_O),
	.OPEN_DIAG_O(OPEN_DIAG_O)
);

// ==== dv/tve_master.sv ====
// controller model flipping between run and stop
`timescale 1ns/100ps
module tve_master (
	input wire clk_i,
	input wire rst_i,
	output reg run_o
);
	reg [4:0] cnt_r;
	// toggle often so values are seen in both states
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 5'h0;
			run_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 5'h1;
			if (cnt_r == 5'h1f)
				run_o <= ~run_o;
		end
	end
endmodule // tve_master

// ==== dv/tb_top.sv ====
// self-checking bench for the encoder
`timescale 1ns/100ps
module tb_top;
	reg clk = 1'b0;
	reg rst, wr, rd, ld;
	reg [3:0] addr;
	reg [31:0] wdat, r;
	reg [1:0] cv, ow;
	reg [47:0] cd;
	reg [19:0] lf = 20'd83712;
	wire run, irq;
	wire [1:0] dg;
	wire [31:0] rdat, pri, leg;
	integer errors = 0, compares = 0, i, a, b;
	integer mvc [0:7] = '{80000, -80000, 94074, 94075, -94074, -94077, 0, -1};
	integer tcc [0:7] = '{4000, 5400, 5401, -2700, -2701, -1, 4001, 0};
	tve_encoder #(.NCH(2)) dut_u (
		.CLK_SYS_I(clk),
		.RST_I(rst),
		.ADDR_I(addr),
		.WDATA_I(wdat),
		.WR_I(wr),
		.RD_I(rd),
		.RDATA_O(rdat),
		.IRQ_O(irq),
		.CONV_VALID_I(cv),
		.CONV_DATA_I(cd),
		.OPEN_WIRE_I(ow),
		.LOAD_SUPPLY_I(ld),
		.CTRL_RUN_I(run),
		.PRI_WORD_O(pri),
		.LEG_WORD_O(leg),
		.OPEN_DIAG_O(dg)
	);
	tve_master mst_u (.clk_i(clk), .rst_i(rst), .run_o(run));
	initial forever #2 clk = ~clk;
	function [19:0] nxt(input [19:0] s);
		nxt = {s[18:0], s[19] ^ s[16]};
	endfunction
	// expected {legacy, primary} for one raw reading
	function [31:0] expw(input md, input integer raw);
		longint s;
		integer hi, lo, t;
		begin
			s = raw;
			if (md)
				s = s * 27648 / 80000;
			hi = md ? 32511 : 5400;
			lo = md ? -32512 : -2700;
			t = s > hi ? hi + 1 : lo - 1;
			if (s > hi || s < lo)
				expw = {t[14:0], 1'b1, s > hi ? 16'h7fff : 16'h8000};
			else
				expw = {s[14:0], 1'b0, s[15:0]};
		end
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("compares=%0d errors=%0d", compares, errors);
			if (errors == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task wreg(input [3:0] ad, input [31:0] d);
		begin
			@(posedge clk);
			wr <= 1'b1;
			addr <= ad;
			wdat <= d;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [3:0] ad);
		begin
			@(posedge clk);
			rd <= 1'b1;
			addr <= ad;
			@(posedge clk);
			rd <= 1'b0;
			#1 r = rdat;
		end
	endtask
	task conv(input integer d0, input integer d1);
		begin
			@(posedge clk);
			cv <= 2'b11;
			cd <= {d1[23:0], d0[23:0]};
			@(posedge clk);
			cv <= 2'b00;
			#1;
		end
	endtask
	initial begin
		#20000;
		errors = errors + 1;
		wrap_up;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1; wr = 1'b0; rd = 1'b0; ld = 1'b0; addr = 4'h0;
		wdat = 32'h0; cv = 2'b00; cd = 48'h0; ow = 2'b00;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		ld <= 1'b1;
		repeat (8) @(posedge clk);
		conv(100, 100);
		chk(leg, 32'h7fff7fff);
		wreg(4'h0, 32'h3);
		conv(100, 100);
		chk(pri, 32'h7fff7fff);
		wreg(4'h0, 32'h5);
		repeat (2) @(posedge clk);
		#1 chk(pri, 32'h7fff7fff);
		for (i = 0; i < 48; i = i + 1) begin
			lf = nxt(lf);
			a = i < 8 ? mvc[i] : lf % 200000 - 100000;
			b = i < 8 ? tcc[i] : lf[19:4] % 12000 - 6000;
			conv(a, b);
			chk({leg[15:0], pri[15:0]}, expw(1'b1, a));
			chk({leg[31:16], pri[31:16]}, expw(1'b0, b));
		end
		chk(irq, 32'h0); // masked-out events stay quiet
		rreg(4'h1);
		chk(r[1:0], 32'h3);
		rreg(4'h1);
		chk(r[1:0], 32'h0); // status read clears
		rreg(4'hf);
		chk(r, 32'h0); // unmapped index
		rreg(4'h0);
		chk(r[5:0], 32'h5); // cfg readback
		rreg(4'h3);
		chk(r, expw(1'b1, a));
		ld <= 1'b0;
		repeat (10) @(posedge clk);
		#1 chk(pri, 32'h7fff7fff);
		ld <= 1'b1;
		repeat (8) @(posedge clk);
		conv(-300, -300);
		chk({leg[15:0], pri[15:0]}, expw(1'b1, -300));
		wreg(4'h2, 32'h4);
		wreg(4'h0, 32'h35);
		ow <= 2'b01;
		repeat (10) @(posedge clk);
		#1 chk(dg, 32'h1);
		chk(irq, 32'h1); // masked-in open wire event
		rreg(4'h1);
		chk(r[2], 32'h1);
		@(posedge clk);
		#1 chk(irq, 32'h0); // cleared by the read
		wrap_up;
	end
endmodule // tb_top
